// File: shared/ascw_map.svh
// Word layout and link timing constants for the amplifier serial control word
`ifndef ASCW_MAP_SVH
`define ASCW_MAP_SVH
`define ASCW_WORD_W        8
`define ASCW_STATE_HI_BIT  7
`define ASCW_GAIN_MODE_BIT 6
`define ASCW_GAIN_MSB      5
`define ASCW_GAIN_W        6
`define ASCW_WORD_RESET    8'h00
`define ASCW_SCLK_HALF_NS  50
`define ASCW_SYS_PERIOD_NS 50
`define ASCW_SCLK_HALF_CYC ((`ASCW_SCLK_HALF_NS + `ASCW_SYS_PERIOD_NS - 1) / `ASCW_SYS_PERIOD_NS)
`endif

// File: shared/ascw_pkg.sv
// Types shared by both ends of the amplifier serial control link
package ascw_pkg;
    typedef logic [7:0] ascw_word_t;
    typedef logic [5:0] ascw_gain_t;
    typedef enum logic [1:0] {
        ASCW_SHUTDOWN,
        ASCW_TX_DISABLED,
        ASCW_LOW_NOISE_TX,
        ASCW_HIGH_GAIN_TX
    } ascw_state_t;
endpackage : ascw_pkg

// File: shared/ascw_if.sv
// Three-wire serial link plus control pins between host and amplifier
`timescale 1ns/1ps
`default_nettype none
interface ascw_if;
    logic select_n;
    logic shift_clk;
    logic serial_data;
    logic transmit_enable_pin;
    logic power_off_pin_n;
    modport host (
        output select_n,
        output shift_clk,
        output serial_data,
        output transmit_enable_pin,
        output power_off_pin_n
    );
    modport device (
        input select_n,
        input shift_clk,
        input serial_data,
        input transmit_enable_pin,
        input power_off_pin_n
    );
endinterface : ascw_if
`default_nettype wire

// File: core/ascw_device.sv
// Amplifier end: shift register, storage latch and chip-state decoder
`timescale 1ns/1ps
`default_nettype none
`include "ascw_map.svh"
module ascw_device (
    ascw_if.device              link,
    output var ascw_pkg::ascw_state_t chip_state,
    output var logic            tx_enable_int,
    output var logic            high_gain_mode,
    output var ascw_pkg::ascw_gain_t gain_code,
    output var logic            analog_on
);
    import ascw_pkg::*;

    // =====================================================
    // Shift register, clocked by the link's shift clock
    // =====================================================
    // Power-off pin doubles as async reset: latch contents are lost
    ascw_word_t shift_reg;
    ascw_word_t shift_next;
    ascw_word_t latch_reg;

    always_comb begin
        shift_next = shift_reg;
        if (!link.select_n) begin
            shift_next = {shift_reg[`ASCW_WORD_W-2:0], link.serial_data};
        end
    end

    always_ff @(posedge link.shift_clk or negedge link.power_off_pin_n) begin
        if (!link.power_off_pin_n) begin
            shift_reg <= `ASCW_WORD_RESET;
        end else begin
            shift_reg <= shift_next;
        end
    end

    // =====================================================
    // Storage latch, loaded on select rising edge
    // =====================================================
    always_ff @(posedge link.select_n or negedge link.power_off_pin_n) begin
        if (!link.power_off_pin_n) begin
            latch_reg <= `ASCW_WORD_RESET;
        end else begin
            latch_reg <= shift_reg;
        end
    end

    // =====================================================
    // Chip-state decode
    // =====================================================
    // Decode is combinational from latch and pin, as in the analog part
    logic upper;
    logic mode;
    assign upper = latch_reg[`ASCW_STATE_HI_BIT];
    assign mode  = latch_reg[`ASCW_GAIN_MODE_BIT];

    always_comb begin
        tx_enable_int  = link.transmit_enable_pin & upper;
        high_gain_mode = mode;
        gain_code      = latch_reg[`ASCW_GAIN_MSB:0];
        analog_on      = link.power_off_pin_n & (upper | mode);
        if (!link.power_off_pin_n || (!upper && !mode)) begin
            chip_state = ASCW_SHUTDOWN;
        end else if (!tx_enable_int) begin
            chip_state = ASCW_TX_DISABLED;
        end else if (mode) begin
            chip_state = ASCW_HIGH_GAIN_TX;
        end else begin
            chip_state = ASCW_LOW_NOISE_TX;
        end
    end
endmodule : ascw_device
`default_nettype wire

// File: core/ascw_host.sv
// Host end: writes one control word over the three-wire link
`timescale 1ns/1ps
`default_nettype none
`include "ascw_map.svh"
module ascw_host #(
    parameter int HALF_CYC = `ASCW_SCLK_HALF_CYC
) (
    input  wire logic           clk_sys,
    input  wire logic           nrst,
    ascw_if.host                link,
    input  wire logic           wr_req,
    input  wire ascw_pkg::ascw_word_t wr_word,
    input  wire logic           tx_enable_req,
    input  wire logic           power_on_req,
    output var logic            busy,
    output var logic            rewrite_needed
);
    import ascw_pkg::*;

    // The half-period counter is eight bits wide
    if (HALF_CYC < 1 || HALF_CYC > 255) begin : g_bad_half_cyc
        $error("HALF_CYC out of range");
    end

    typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_END} ascw_hstate_t;

    // =====================================================
    // Serial engine
    // =====================================================
    ascw_hstate_t st_reg, st_next;
    ascw_word_t   sh_reg, sh_next;
    logic [3:0]   bit_reg, bit_next;
    logic [7:0]   cnt_reg, cnt_next;
    logic         sel_n_reg, sel_n_next;
    logic         sclk_reg, sclk_next;
    logic         pwr_reg, pwr_next;
    logic         transmit_enable_pin_reg, transmit_enable_pin_next;
    logic         rew_reg, rew_next;
    logic         busy_reg, busy_next;

    always_comb begin
        st_next    = st_reg;
        sh_next    = sh_reg;
        bit_next   = bit_reg;
        cnt_next   = cnt_reg;
        sel_n_next = sel_n_reg;
        sclk_next  = sclk_reg;
        pwr_next   = power_on_req;
        transmit_enable_pin_next  = tx_enable_req;
        rew_next   = rew_reg;
        unique case (st_reg)
            H_IDLE: begin
                if (wr_req && pwr_reg) begin
                    sh_next    = wr_word;
                    bit_next   = 4'h0;
                    cnt_next   = 8'h00;
                    sel_n_next = 1'b0;
                    st_next    = H_LOW;
                end
            end
            H_LOW: begin
                if (cnt_reg == 8'(HALF_CYC - 1)) begin
                    cnt_next  = 8'h00;
                    sclk_next = 1'b1;
                    st_next   = H_HIGH;
                end else begin
                    cnt_next = cnt_reg + 8'h01;
                end
            end
            H_HIGH: begin
                if (cnt_reg == 8'(HALF_CYC - 1)) begin
                    cnt_next  = 8'h00;
                    sclk_next = 1'b0;
                    sh_next   = {sh_reg[6:0], 1'b0};
                    bit_next  = bit_reg + 4'h1;
                    st_next   = (bit_reg == 4'(`ASCW_WORD_W - 1)) ? H_END : H_LOW;
                end else begin
                    cnt_next = cnt_reg + 8'h01;
                end
            end
            H_END: begin
                if (cnt_reg == 8'(HALF_CYC - 1)) begin
                    sel_n_next = 1'b1;
                    rew_next   = 1'b0;
                    st_next    = H_IDLE;
                end else begin
                    cnt_next = cnt_reg + 8'h01;
                end
            end
        endcase
        // Latch is lost while powered off; this wins over the end of a frame
        if (!pwr_reg) begin
            rew_next = 1'b1;
        end
        busy_next = (st_next != H_IDLE);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_reg    <= H_IDLE;
            sh_reg    <= 8'h00;
            bit_reg   <= 4'h0;
            cnt_reg   <= 8'h00;
            sel_n_reg <= 1'b1;
            sclk_reg  <= 1'b0;
            pwr_reg   <= 1'b0;
            transmit_enable_pin_reg  <= 1'b0;
            rew_reg   <= 1'b1;
            busy_reg  <= 1'b0;
        end else begin
            st_reg    <= st_next;
            sh_reg    <= sh_next;
            bit_reg   <= bit_next;
            cnt_reg   <= cnt_next;
            sel_n_reg <= sel_n_next;
            sclk_reg  <= sclk_next;
            pwr_reg   <= pwr_next;
            transmit_enable_pin_reg  <= transmit_enable_pin_next;
            rew_reg   <= rew_next;
            busy_reg  <= busy_next;
        end
    end

    assign link.select_n            = sel_n_reg;
    assign link.shift_clk           = sclk_reg;
    assign link.serial_data         = sh_reg[7];
    assign link.transmit_enable_pin = transmit_enable_pin_reg;
    assign link.power_off_pin_n     = pwr_reg;
    assign busy                     = busy_reg;
    assign rewrite_needed           = rew_reg;
endmodule : ascw_host
`default_nettype wire

// File: test/ascw_sva.sv
// Checker on the control link and the amplifier decode outputs
`timescale 1ns/1ps
`default_nettype none
module ascw_sva (
    input wire logic                  clk_sys,
    input wire logic                  nrst,
    input wire logic                  select_n,
    input wire logic                  shift_clk,
    input wire logic                  transmit_enable_pin,
    input wire logic                  power_off_pin_n,
    input wire ascw_pkg::ascw_state_t chip_state,
    input wire logic                  tx_enable_int,
    input wire logic                  high_gain_mode,
    input wire ascw_pkg::ascw_gain_t  gain_code,
    input wire logic                  analog_on
);
    import ascw_pkg::*;
    logic [3:0] rises_reg;
    logic [3:0] rises_next;
    logic       sclk_reg;
    // ==========================================
    // Shift clock rises counted per frame
    always_comb begin
        rises_next = rises_reg;
        if (select_n) rises_next = 4'h0;
        else if (shift_clk && !sclk_reg) rises_next = rises_reg + 4'h1;
    end
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rises_reg <= 4'h0;
            sclk_reg  <= 1'b0;
        end else begin
            rises_reg <= rises_next;
            sclk_reg  <= shift_clk;
        end
    end
    // ==========================================
    // Properties
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence frame_end_s; $rose(select_n); endsequence
    sequence pin_held_s; power_off_pin_n && $past(power_off_pin_n); endsequence
    word_len_a: assert property (frame_end_s |-> rises_reg == 4'h8)
        else $error("Frame without eight shift clocks");
    idle_clk_a: assert property (select_n && $past(select_n) |-> !shift_clk)
        else $error("Shift clock moved outside a frame");
    latch_hold_a: assert property (pin_held_s ##0 $changed(gain_code) |-> frame_end_s)
        else $error("Gain changed without select rising");
    transmit_enable_pin_pin_a: assert property (tx_enable_int |-> transmit_enable_pin)
        else $error("Transmit enable without pin");
    txdis_pin_a: assert property (analog_on && !transmit_enable_pin |-> chip_state == ASCW_TX_DISABLED)
        else $error("Pin low but not transmit disabled");
    high_gain_a: assert property (chip_state == ASCW_HIGH_GAIN_TX |-> tx_enable_int && high_gain_mode)
        else $error("High gain state without its causes");
    low_noise_a: assert property (chip_state == ASCW_LOW_NOISE_TX |-> tx_enable_int && !high_gain_mode)
        else $error("Low noise state without its causes");
    soft_off_a: assert property (chip_state == ASCW_SHUTDOWN |-> !analog_on)
        else $error("Analog on during shutdown");
    pin_clear_a: assert property (!power_off_pin_n |-> chip_state == ASCW_SHUTDOWN && gain_code == 6'h00)
        else $error("Power off pin did not clear latch");
endmodule : ascw_sva
`default_nettype wire

// File: test/amp_serial_control_word_tb_top.sv
// Bench joining host and amplifier ends over the control link
`timescale 1ns/1ps
`default_nettype none
module amp_serial_control_word_tb_top;
    import ascw_pkg::*;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic        wr_req = 1'b0;
    ascw_word_t  wr_word = 8'h00;
    logic        tx_enable_req = 1'b0;
    logic        power_on_req = 1'b0;
    logic        busy, rewrite_needed, tx_enable_int, high_gain_mode, analog_on;
    ascw_state_t chip_state;
    ascw_gain_t  gain_code;
    int          n_fail = 0;
    int          compares = 0;
    ascw_if link ();
    always #25 clk_sys = ~clk_sys;
    ascw_host i_ascw_host (.clk_sys(clk_sys), .nrst(nrst), .link(link.host), .wr_req(wr_req), .wr_word(wr_word),
        .tx_enable_req(tx_enable_req), .power_on_req(power_on_req), .busy(busy), .rewrite_needed(rewrite_needed));
    ascw_device i_ascw_device (.link(link.device), .chip_state(chip_state), .tx_enable_int(tx_enable_int),
        .high_gain_mode(high_gain_mode), .gain_code(gain_code), .analog_on(analog_on));
    ascw_sva i_ascw_sva (.clk_sys(clk_sys), .nrst(nrst), .select_n(link.select_n), .shift_clk(link.shift_clk),
        .transmit_enable_pin(link.transmit_enable_pin), .power_off_pin_n(link.power_off_pin_n),
        .chip_state(chip_state), .tx_enable_int(tx_enable_int), .high_gain_mode(high_gain_mode),
        .gain_code(gain_code), .analog_on(analog_on));
    // ==========================================
    // Shared tasks
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_dev(input ascw_word_t w, input logic en);
        ascw_state_t st;
        st = (w[7:6] == 2'b00) ? ASCW_SHUTDOWN : (!(en && w[7])) ? ASCW_TX_DISABLED
            : (w[6] ? ASCW_HIGH_GAIN_TX : ASCW_LOW_NOISE_TX);
        chk("state", {6'h00, st}, {6'h00, chip_state});
        chk("gain", {2'h0, w[5:0]}, {2'h0, gain_code});
        chk("flags", {5'h00, en & w[7], w[6], w[7:6] != 2'b00}, {5'h00, tx_enable_int, high_gain_mode, analog_on});
    endtask : chk_dev
    task automatic wr(input ascw_word_t w);
        int i;
        i = 0;
        wr_word = w;
        wr_req = 1'b1;
        while (busy !== 1'b1 && i < 20) begin
            @(negedge clk_sys);
            i++;
        end
        wr_req = 1'b0;
        chk("busy rose", 8'h01, {7'h00, busy});
        while (busy !== 1'b0 && i < 200) begin
            @(negedge clk_sys);
            i++;
        end
        chk("busy", 8'h00, {7'h00, busy});
        @(negedge clk_sys);
    endtask : wr
    // ==========================================
    // Scenarios
    task automatic t_reset();
        chk_dev(8'h00, 1'b0);
        chk("rewrite", 8'h01, {7'h00, rewrite_needed});
    endtask : t_reset
    task automatic t_modes();
        ascw_word_t words[6] = '{8'hc5, 8'h8d, 8'h2a, 8'h5a, 8'hff, 8'h00};
        power_on_req = 1'b1;
        repeat (3) @(negedge clk_sys);
        for (int en = 0; en < 2; en++) begin
            tx_enable_req = en[0];
            repeat (2) @(negedge clk_sys);
            foreach (words[k]) begin
                wr(words[k]);
                chk_dev(words[k], en[0]);
            end
        end
    endtask : t_modes
    task automatic t_power();
        wr(8'hdb);
        power_on_req = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk_dev(8'h00, 1'b1);
        power_on_req = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk_dev(8'h00, 1'b1);
        chk("rewrite", 8'h01, {7'h00, rewrite_needed});
        wr(8'h95);
        chk_dev(8'h95, 1'b1);
        chk("rewrite", 8'h00, {7'h00, rewrite_needed});
        // Low-noise mode stays legal at the top gain code
        wr(8'hbf);
        chk_dev(8'hbf, 1'b1);
    endtask : t_power
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (2) @(negedge clk_sys);
        nrst = 1'b1;
        t_reset();
        t_modes();
        t_power();
        finish_test();
    end
    initial begin
        #200000;
        n_fail++;
        finish_test();
    end
endmodule : amp_serial_control_word_tb_top
`default_nettype wire
